// ==== src/sfrac_map.vh ====
// Address map, field positions and reset values for the register window block
`ifndef SFRAC_MAP_VH
`define SFRAC_MAP_VH
`define SFRAC_UPPER_BIT 7
`define SFRAC_BITADDR_MASK 8'h07
`define SFRAC_AUX_ADDR 8'hA2
`define SFRAC_AUX_RESET 8'h00
`define SFRAC_AUX_UNUSED 8'hC2
`define SFRAC_DEV_RESET 8'h00
`define SFRAC_DEV0_ADDR 8'h80
`define SFRAC_DEV_COUNT 8
`define SFRAC_BIT_IRQ_MODE 5
`define SFRAC_BIT_LP_SAMPLE 4
`define SFRAC_BIT_SOFT_RST 3
`define SFRAC_BIT_CONV_EN 2
`define SFRAC_BIT_PTR_SEL 0
`define SFRAC_ALL_ONES 8'hFF
`define SFRAC_LP_PERIOD 4'hF
`define SFRAC_RAM_WORDS 256
`define SFRAC_SOFT_RESET_REQUEST_HOLD 2'h3
`endif

// ==== src/sfrac_window.v ====
// Direct register window, scratch RAM and auxiliary control register
// Function
// - Special registers decode only at 80h-FFh and only under direct addressing.
// - Scratch RAM takes direct and indirect accesses; indirect upper accesses reach RAM.
// - Only register addresses with low three bits zero accept single-bit writes.
// - A single-bit write changes only the selected bit.
// - Unmapped locations and unimplemented bits read as one.
// - Brownout flag resets the chip when irq mode is 0, raises an interrupt when 1.
// - With low-power sampling set the detector runs one sixteenth of power-down time, else always.
// - In power-down with detection enabled the internal RC oscillator is enabled.
// - Writing one to the soft reset bit resets the chip like a hardware reset.
// - Converter enable bit switches the converter off at 0 and on at 1.
// - Pointer select routes pointer operations to the standard or the second pointer.
`timescale 1ns/1ps
`include "sfrac_map.vh"
module sfrac_window #(
    parameter RAM_WORDS = `SFRAC_RAM_WORDS,
    parameter DEV_COUNT = `SFRAC_DEV_COUNT
) (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Core access port
    input wire acc_valid,
    input wire acc_write,
    input wire acc_direct,
    input wire acc_bit,
    input wire [7:0] acc_addr,
    input wire [2:0] acc_bitsel,
    input wire [7:0] acc_wdata,
    output reg [7:0] acc_rdata_ff,
    output reg acc_rvalid_ff,
    // Pins from brownout and power logic
    input wire brownout_flag,
    input wire brownout_detector,
    input wire power_down,
    // Controls to surrounding logic
    output reg chip_reset_ff,
    output reg brownout_irq_ff,
    output reg detector_on_ff,
    output reg rc_osc_en_ff,
    output reg converter_enable_ff,
    output reg pointer_select_ff,
    output reg [7:0] aux_control_ff,
    // Generic peripheral register images at 80h upward
    output reg [8*DEV_COUNT-1:0] dev_regs_ff
);

    reg [7:0] ram_mem [0:RAM_WORDS-1];
    reg [7:0] nxt_aux;
    reg [7:0] cur_val;
    reg [7:0] wr_val;
    reg [7:0] rd_val;
    reg [1:0] soft_reset_request_cnt_ff;
    reg [3:0] lp_cnt_ff;
    reg bof_s1_ff, bof_s2_ff;
    reg bod_s1_ff, bod_s2_ff;
    reg pd_s1_ff, pd_s2_ff;
    reg sfr_hit;
    reg aux_hit;
    reg dev_hit;
    reg ram_hit;
    reg bit_ok;
    reg [2:0] dev_idx;
    genvar g;

    // Decode of the access
    always @* begin
        sfr_hit = acc_valid && acc_direct && acc_addr[`SFRAC_UPPER_BIT];
        ram_hit = acc_valid && !sfr_hit;
        aux_hit = sfr_hit && (acc_addr == `SFRAC_AUX_ADDR);
        dev_hit = sfr_hit && (acc_addr < (`SFRAC_DEV0_ADDR + DEV_COUNT));
        dev_idx = acc_addr[2:0];
        bit_ok = (acc_addr & `SFRAC_BITADDR_MASK) == 8'h00;
    end

    // Current value at the addressed location
    always @* begin
        cur_val = `SFRAC_ALL_ONES;
        if (aux_hit) begin
            cur_val = aux_control_ff | `SFRAC_AUX_UNUSED;
        end else if (dev_hit) begin
            cur_val = dev_regs_ff[dev_idx*8 +: 8];
        end else if (ram_hit) begin
            cur_val = ram_mem[acc_addr];
        end else begin
            cur_val = `SFRAC_ALL_ONES;
        end
    end

    // Write value: bit writes merge into the old byte, others replace it
    always @* begin
        wr_val = acc_wdata;
        if (acc_bit) begin
            wr_val = cur_val;
            wr_val[acc_bitsel] = acc_wdata[0];
        end
    end

    // Read value: bit reads return the bit in position 0
    always @* begin
        rd_val = cur_val;
        if (acc_bit) begin
            rd_val = {7'h00, cur_val[acc_bitsel]};
        end
    end

    // Bit write to a register not on an eight-byte boundary is ignored
    wire wr_ok = acc_valid && acc_write && (!acc_bit || !sfr_hit || bit_ok);

    always @* begin
        nxt_aux = aux_control_ff;
        if (wr_ok && aux_hit) begin
            nxt_aux = wr_val & ~`SFRAC_AUX_UNUSED;
        end
    end

    // Input synchronisers
    always @(posedge clk_sys) begin
        bof_s1_ff <= brownout_flag;
        bof_s2_ff <= bof_s1_ff;
        bod_s1_ff <= brownout_detector;
        bod_s2_ff <= bod_s1_ff;
        pd_s1_ff <= power_down;
        pd_s2_ff <= pd_s1_ff;
    end

    // RAM survives reset, so it has no reset branch
    always @(posedge clk_sys) begin
        if (wr_ok && ram_hit) begin
            ram_mem[acc_addr] <= wr_val;
        end
    end

    // Register file and bus answer
    always @(posedge clk_sys) begin
        if (!rstn || chip_reset_ff) begin
            aux_control_ff <= `SFRAC_AUX_RESET;
            acc_rdata_ff <= `SFRAC_ALL_ONES;
            acc_rvalid_ff <= 1'b0;
        end else begin
            aux_control_ff <= nxt_aux;
            if (aux_control_ff[`SFRAC_BIT_SOFT_RST]) begin
                aux_control_ff[`SFRAC_BIT_SOFT_RST] <= 1'b0;
            end
            acc_rvalid_ff <= acc_valid && !acc_write;
            // Read data holds until the next read
            if (acc_valid && !acc_write) begin
                acc_rdata_ff <= rd_val;
            end
        end
    end

    // Generic peripheral register images, one per entry
    generate
        for (g = 0; g < DEV_COUNT; g = g + 1) begin : gen_dev
            always @(posedge clk_sys) begin
                if (!rstn || chip_reset_ff) begin
                    dev_regs_ff[g*8 +: 8] <= `SFRAC_DEV_RESET;
                end else if (wr_ok && dev_hit && dev_idx == g) begin
                    dev_regs_ff[g*8 +: 8] <= wr_val;
                end
            end
        end
    endgenerate

    // Soft reset stretch and chip reset request
    always @(posedge clk_sys) begin
        if (!rstn) begin
            soft_reset_request_cnt_ff <= 2'h0;
            chip_reset_ff <= 1'b0;
        end else begin
            if (aux_control_ff[`SFRAC_BIT_SOFT_RST]) begin
                soft_reset_request_cnt_ff <= `SFRAC_SOFT_RESET_REQUEST_HOLD;
            end else if (soft_reset_request_cnt_ff != 2'h0) begin
                soft_reset_request_cnt_ff <= soft_reset_request_cnt_ff - 2'h1;
            end
            // Brownout reset only when interrupt mode is off
            chip_reset_ff <= aux_control_ff[`SFRAC_BIT_SOFT_RST] || (soft_reset_request_cnt_ff > 2'h1)
                || (bof_s2_ff && !aux_control_ff[`SFRAC_BIT_IRQ_MODE]);
        end
    end

    // Brownout interrupt, detector duty cycle and oscillator
    always @(posedge clk_sys) begin
        if (!rstn) begin
            brownout_irq_ff <= 1'b0;
            detector_on_ff <= 1'b0;
            rc_osc_en_ff <= 1'b0;
            lp_cnt_ff <= 4'h0;
            converter_enable_ff <= 1'b0;
            pointer_select_ff <= 1'b0;
        end else begin
            brownout_irq_ff <= bof_s2_ff && aux_control_ff[`SFRAC_BIT_IRQ_MODE];
            lp_cnt_ff <= (pd_s2_ff && bod_s2_ff) ? lp_cnt_ff + 4'h1 : 4'h0;
            if (!bod_s2_ff) begin
                detector_on_ff <= 1'b0;
            end else if (pd_s2_ff && aux_control_ff[`SFRAC_BIT_LP_SAMPLE]) begin
                detector_on_ff <= (lp_cnt_ff == `SFRAC_LP_PERIOD);
            end else begin
                detector_on_ff <= 1'b1;
            end
            rc_osc_en_ff <= pd_s2_ff && bod_s2_ff;
            converter_enable_ff <= aux_control_ff[`SFRAC_BIT_CONV_EN];
            pointer_select_ff <= aux_control_ff[`SFRAC_BIT_PTR_SEL];
        end
    end

endmodule // sfrac_window

// ==== verification/sfrac_props.sv ====
// Port-level checker for the register window block
`timescale 1ns/1ps
module sfrac_props (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Core access port
    input wire acc_valid,
    input wire acc_write,
    input wire acc_direct,
    input wire acc_bit,
    input wire [7:0] acc_addr,
    input wire [7:0] acc_wdata,
    input wire [7:0] acc_rdata_ff,
    input wire acc_rvalid_ff,
    // Control outputs
    input wire chip_reset_ff,
    input wire converter_enable_ff,
    input wire pointer_select_ff,
    input wire [7:0] aux_control_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire dwr = acc_valid && acc_write && acc_direct && !chip_reset_ff;
    wire auxwr = dwr && !acc_bit && acc_addr == 8'hA2;
    wire drd = acc_valid && !acc_write && acc_direct && !acc_bit;
    property p_unmap; drd && acc_addr == 8'hA3 |=> acc_rdata_ff == 8'hFF; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not FF");
    property p_auxrd; drd && acc_addr == 8'hA2 |=> acc_rdata_ff[7:6] == 2'b11 && acc_rdata_ff[1]; endproperty
    a_auxrd: assert property (p_auxrd) else $error("unused aux bits not one");
    property p_conv; auxwr && !acc_wdata[3] |-> ##2 converter_enable_ff == $past(acc_wdata[2], 2); endproperty
    a_conv: assert property (p_conv) else $error("converter enable wrong");
    property p_ptr; auxwr && !acc_wdata[3] |-> ##2 pointer_select_ff == $past(acc_wdata[0], 2); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer select wrong");
    property p_soft_reset_request; auxwr && acc_wdata[3] |-> ##2 chip_reset_ff; endproperty
    a_soft_reset_request: assert property (p_soft_reset_request) else $error("soft reset missing");
    property p_selfclr; $rose(chip_reset_ff) |-> !aux_control_ff[3]; endproperty
    a_selfclr: assert property (p_selfclr) else $error("soft reset bit not cleared");
    property p_bitref; dwr && acc_bit && acc_addr == 8'hA2 |=> $stable(aux_control_ff); endproperty
    a_bitref: assert property (p_bitref) else $error("bit write took effect");
    property p_ind; acc_valid && acc_write && !acc_direct && acc_addr[7] && !chip_reset_ff |=> $stable(aux_control_ff); endproperty
    a_ind: assert property (p_ind) else $error("indirect write hit register");
    c_soft_reset_request: cover property ($rose(chip_reset_ff));
    c_ff: cover property (acc_rvalid_ff && acc_rdata_ff == 8'hFF);
    c_bit: cover property (acc_valid && acc_bit && acc_write);
endmodule // sfrac_props

// ==== verification/sfrac_pwr_model.sv ====
// Brownout and power-mode pin model facing the window
`timescale 1ns/1ps
module sfrac_pwr_model (
    // Clock and command
    input wire clk_sys,
    input wire [2:0] cmd,
    // Pins toward the window
    output logic brownout_flag,
    output logic brownout_detector,
    output logic power_down
);
    // Pins move just after the edge, as real async sources would not align
    always @(posedge clk_sys) {brownout_flag, brownout_detector, power_down} <= #1 cmd;
endmodule // sfrac_pwr_model

// ==== verification/testbench.sv ====
// Self-checking bench for the register window block
`timescale 1ns/1ps
module testbench;
    logic clk_sys, rstn, acc_valid, acc_write, acc_direct, acc_bit, acc_rvalid_ff, chip_reset_ff;
    logic [7:0] acc_addr, acc_wdata, acc_rdata_ff, aux_control_ff, cnt;
    logic [2:0] acc_bitsel, cmd;
    logic [63:0] dev_regs_ff;
    logic brownout_flag, brownout_detector, power_down, brownout_irq_ff, detector_on_ff;
    logic rc_osc_en_ff, converter_enable_ff, pointer_select_ff;
    int n_fail = 0;
    int n_compared = 0;
    sfrac_window dut (.*);
    sfrac_pwr_model pwr (.*);
    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Idle cycle after each access keeps the two-cycle checks unambiguous
    task automatic acc(logic w, logic d, logic b, logic [7:0] a, logic [2:0] s, logic [7:0] wd);
        {acc_valid, acc_write, acc_direct, acc_bit, acc_addr, acc_bitsel, acc_wdata} = {1'b1, w, d, b, a, s, wd};
        @(posedge clk_sys) #1 acc_valid = 0;
        @(posedge clk_sys) #1;
    endtask
    // Read answer stands one cycle, so look right after the taking edge
    task automatic rd(logic d, logic b, logic [7:0] a, logic [2:0] s, logic [7:0] exp, string nm);
        {acc_valid, acc_write, acc_direct, acc_bit, acc_addr, acc_bitsel, acc_wdata} = {1'b1, 1'b0, d, b, a, s, 8'h00};
        @(posedge clk_sys) #1 acc_valid = 0;
        chk({nm, "_rvalid"}, 8'h01, {7'h00, acc_rvalid_ff});
        chk(nm, exp, acc_rdata_ff);
        @(posedge clk_sys) #1;
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {rstn, acc_valid, acc_write, acc_direct, acc_bit, acc_addr, acc_bitsel, acc_wdata, cmd} = 0;
        repeat (8) @(posedge clk_sys);
        #1 rstn = 1;
        rd(1, 0, 8'hA2, 0, 8'hC2, "aux_reset");
        rd(1, 0, 8'hA3, 0, 8'hFF, "unmapped");
        acc(1, 1, 0, 8'hA2, 0, 8'h35);
        rd(1, 0, 8'hA2, 0, 8'hF7, "aux_write");
        chk("conv_en", 8'h01, {7'h00, converter_enable_ff});
        chk("ptr_sel", 8'h01, {7'h00, pointer_select_ff});
        acc(1, 0, 0, 8'hA2, 0, 8'h5A);
        rd(1, 0, 8'hA2, 0, 8'hF7, "aux_indirect");
        rd(0, 0, 8'hA2, 0, 8'h5A, "ram_indirect");
        acc(1, 1, 1, 8'hA2, 3'h2, 8'h00);
        rd(1, 0, 8'hA2, 0, 8'hF7, "aux_bitwrite");
        acc(1, 1, 0, 8'h80, 0, 8'hA5);
        acc(1, 1, 1, 8'h80, 3'h6, 8'h01);
        rd(1, 0, 8'h80, 0, 8'hE5, "dev_bitwrite");
        rd(1, 1, 8'h80, 3'h6, 8'h01, "dev_bitread");
        cmd = 3'b100;
        repeat (4) @(posedge clk_sys);
        #1 chk("irq_mode", 8'h01, {7'h00, brownout_irq_ff});
        chk("no_reset", 8'h00, {7'h00, chip_reset_ff});
        cmd = 3'b011;
        repeat (4) @(posedge clk_sys);
        #1 chk("rc_osc", 8'h01, {7'h00, rc_osc_en_ff});
        cnt = 0;
        repeat (32) begin
            @(posedge clk_sys) #1 cnt = cnt + {7'h00, detector_on_ff};
        end
        chk("det_duty", 8'h02, cnt);
        cmd = 3'b000;
        acc(1, 1, 0, 8'hA2, 0, 8'h08);
        @(posedge clk_sys) #1 chk("soft_reset", 8'h01, {7'h00, chip_reset_ff});
        repeat (4) @(posedge clk_sys);
        rd(1, 0, 8'hA2, 0, 8'hC2, "aux_selfclr");
        cmd = 3'b100;
        repeat (4) @(posedge clk_sys);
        #1 chk("bo_reset", 8'h01, {7'h00, chip_reset_ff});
        cmd = 3'b000;
        repeat (8) @(posedge clk_sys);
        print_verdict;
    end
    initial begin
        #200000;
        n_fail++;
        print_verdict;
    end
endmodule // testbench
bind sfrac_window sfrac_props u_props (.*);
